// [design/cmp_timer_regs.vh]
// register map, field positions, reset values and divider counts
`ifndef CMP_TIMER_REGS_VH
`define CMP_TIMER_REGS_VH

// register indices (byte address is four times the index)
`define IDX_TIMER_CONTROL      16'hfed0
`define IDX_TIMER_FLAGS        16'hfed1
`define IDX_COMPARE_A          16'hfed2
`define IDX_COMPARE_B          16'hfed3
`define IDX_TIMER_COUNT        16'hfed4
// standby control register, index of our own
`define IDX_STANDBY_CTRL       16'hfed5

// reset values
`define RST_TIMER_CONTROL      8'h00
`define RST_TIMER_FLAGS        8'h10
`define RST_COMPARE            8'hff
`define RST_TIMER_COUNT        8'h00

// timer_control fields
`define TC_MATCH_B_IE          7
`define TC_MATCH_A_IE          6
`define TC_WRAP_IE             5
`define TC_CLR_HI              4
`define TC_CLR_LO              3
`define TC_CKS_HI              2
`define TC_CKS_LO              0

// timer_flags_and_output_select fields
`define TF_MATCH_B             7
`define TF_MATCH_A             6
`define TF_WRAP                5
`define TF_FIXED_ONE           4

// clock select codes
`define CKS_STOP0              3'h0
`define CKS_DIV8               3'h1
`define CKS_DIV64              3'h2
`define CKS_DIV1024            3'h3
`define CKS_STOP1              3'h4
`define CKS_EXT_RISE           3'h5
`define CKS_EXT_FALL           3'h6
`define CKS_EXT_BOTH           3'h7

// counter clear codes
`define CLR_NONE               2'h0
`define CLR_MATCH_A            2'h1
`define CLR_MATCH_B            2'h2
`define CLR_EXT                2'h3

// output select codes
`define OS_KEEP                2'h0
`define OS_LOW                 2'h1
`define OS_HIGH                2'h2
`define OS_TOGGLE              2'h3

// prescaler divide ratios
`define DIV_A                  8
`define DIV_B                  64
`define DIV_C                  1024

`endif

// [design/cmp_timer.v]
// eight bit compare timer with avalon-mm register slave
`timescale 1ns/1ps
`include "cmp_timer_regs.vh"

module cmp_timer (
   // clock and reset
   input  wire        i_clk_sys,
   input  wire        i_rst_n,
   // avalon-mm slave
   input  wire [15:0] i_avs_address,
   input  wire        i_avs_read,
   input  wire        i_avs_write,
   input  wire [31:0] i_avs_writedata,
   input  wire [3:0]  i_avs_byteenable,
   output reg  [31:0] o_avs_readdata,
   output reg         o_avs_waitrequest,
   output reg  [1:0]  o_avs_response,
   // standby entry and transfer controller service
   input  wire        i_standby,
   input  wire        i_transfer_ack_a,
   input  wire        i_transfer_ack_b,
   // external pins
   input  wire        i_external_count_in,
   input  wire        i_external_clear_in,
   output reg         o_timer_wave_out,
   output reg         o_timer_wave_oe_n,
   // interrupt requests
   output reg         o_match_a_irq,
   output reg         o_match_b_irq,
   output reg         o_wrap_irq
);

   // register state
   reg  [7:0]  timer_control_r;
   reg  [2:0]  flags_r;            // b, a, wrap
   reg  [2:0]  flags_seen_r;       // flag read while set
   reg  [3:0]  out_sel_r;
   reg  [7:0]  compare_constant_a_r;
   reg  [7:0]  compare_constant_b_r;
   reg  [7:0]  timer_count_r;

   // divider and pin edge history
   reg  [9:0]  prescale_r;
   reg         ext_count_d_r;
   reg         ext_clear_d_r;

   // wave level and bus answer phase
   reg         wave_r;
   reg         pend_r;             // bus access answered next cycle

   // decoded fields
   wire [2:0]  clock_select  = timer_control_r[`TC_CKS_HI:`TC_CKS_LO];
   wire [1:0]  counter_clear = timer_control_r[`TC_CLR_HI:`TC_CLR_LO];

   // the five registers sit on word addresses; the printed index is
   // folded into 14 bits and shifted up by two to form the byte address
   // byte lane of an index: address is index times four
   function [15:0] word_index;
      input [15:0] addr;
      begin
         word_index = {2'h0, addr[15:2]};
      end
   endfunction

   function hit;
      input [15:0] addr;
      input [15:0] idx;
      begin
         hit = (word_index(addr) == (idx & 16'h3fff)) && (addr[1:0] == 2'h0);
      end
   endfunction

   // bus decode, only in the cycle an access is taken
   // an access is taken once: the answer cycle that follows blocks a
   // second take of the same held request, so every access costs two
   // clocks and a write lands on its taking edge
   wire        take     = (i_avs_read | i_avs_write) & ~pend_r;
   wire        wr_lane  = i_avs_write & take & i_avs_byteenable[0];
   wire        rd_take  = i_avs_read & take;
   wire [7:0]  wdat     = i_avs_writedata[7:0];

   // per register write strobes, byte lane 0 only
   wire        wr_ctl   = wr_lane & hit(i_avs_address, `IDX_TIMER_CONTROL);
   wire        wr_flg   = wr_lane & hit(i_avs_address, `IDX_TIMER_FLAGS);
   wire        wr_cpa   = wr_lane & hit(i_avs_address, `IDX_COMPARE_A);
   wire        wr_cpb   = wr_lane & hit(i_avs_address, `IDX_COMPARE_B);
   wire        wr_cnt   = wr_lane & hit(i_avs_address, `IDX_TIMER_COUNT);

   // flag register read, arms the software clear
   wire        rd_flg   = rd_take & hit(i_avs_address, `IDX_TIMER_FLAGS);

   // address lands on one of the five registers
   wire        mapped   = hit(i_avs_address, `IDX_TIMER_CONTROL)
                        | hit(i_avs_address, `IDX_TIMER_FLAGS)
                        | hit(i_avs_address, `IDX_COMPARE_A)
                        | hit(i_avs_address, `IDX_COMPARE_B)
                        | hit(i_avs_address, `IDX_TIMER_COUNT);

   // prescaler taps
   // one free-running divider feeds all three taps, so a tap fires in
   // the single cycle its low bits are all ones; switching between taps
   // may give one short first period, which software must allow for
   wire        tick8    = (prescale_r[2:0] == 3'h7);
   wire        tick64   = (prescale_r[5:0] == 6'h3f);
   wire        tick1024 = (prescale_r == 10'h3ff);

   // external edges
   // the pin is compared with last cycle's sample; the history flop
   // resets low, the idle level of the pin, so no false edge follows
   // reset; levels must stand one clock or more to be seen
   wire        ext_rise = i_external_count_in & ~ext_count_d_r;
   wire        ext_fall = ~i_external_count_in & ext_count_d_r;

   // count pulse from the selected source
   // codes 000 and 100 fall to the default branch and stop the count
   // the external codes count pin edges, so pin pulses set the rate
   reg         count_pulse;
   always @* begin
      case (clock_select)
         `CKS_DIV8:     count_pulse = tick8;
         `CKS_DIV64:    count_pulse = tick64;
         `CKS_DIV1024:  count_pulse = tick1024;
         `CKS_EXT_RISE: count_pulse = ext_rise;
         `CKS_EXT_FALL: count_pulse = ext_fall;
         `CKS_EXT_BOTH: count_pulse = ext_rise | ext_fall;
         default:       count_pulse = 1'b0;
      endcase
   end


   // match event in last match cycle, just before the advance
   // a match is only an event when a count pulse arrives while the
   // count equals the constant, so a stopped counter sitting on the
   // constant sets nothing and toggles nothing
   wire        match_a  = count_pulse
                        & (timer_count_r == compare_constant_a_r);
   wire        match_b  = count_pulse
                        & (timer_count_r == compare_constant_b_r);

   wire        wrap     = count_pulse & (timer_count_r == 8'hff);

   wire        ext_clr  = (counter_clear == `CLR_EXT)
                        & i_external_clear_in & ~ext_clear_d_r;

   wire        cmp_clr  = ((counter_clear == `CLR_MATCH_A) & match_a)
                        | ((counter_clear == `CLR_MATCH_B) & match_b);

   // free running prescaler and edge history
   // the divider never stops, not even in standby: only the selected
   // tap matters, and standby holds the count at zero anyway
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prescale_r    <= 10'h000;
         ext_count_d_r <= 1'b0;
         ext_clear_d_r <= 1'b0;
      end else begin
         prescale_r    <= prescale_r + 10'h001;
         ext_count_d_r <= i_external_count_in;
         ext_clear_d_r <= i_external_clear_in;
      end
   end

   // counter
   // priority: standby, then a bus write, then a clear, then a count
   // pulse; a write in the cycle of a pulse drops that pulse, and a
   // clear in the cycle of a pulse leaves the count at zero
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_count_r <= `RST_TIMER_COUNT;
      end else if (i_standby) begin
         timer_count_r <= `RST_TIMER_COUNT;
      end else if (wr_cnt) begin
         timer_count_r <= wdat;
      end else if (ext_clr | cmp_clr) begin
         timer_count_r <= 8'h00;
      end else if (count_pulse) begin
         timer_count_r <= timer_count_r + 8'h01;
      end
   end

   // control and constant registers
   // a write to the flag register also loads the output selects;
   // its flag bits are handled in the flag logic below
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_control_r      <= `RST_TIMER_CONTROL;
         compare_constant_a_r <= `RST_COMPARE;
         compare_constant_b_r <= `RST_COMPARE;
         out_sel_r            <= 4'h0;
      end else if (i_standby) begin
         timer_control_r      <= `RST_TIMER_CONTROL;
         compare_constant_a_r <= `RST_COMPARE;
         compare_constant_b_r <= `RST_COMPARE;
         out_sel_r            <= 4'h0;
      end else begin
         // bus writes, byte lane 0 only
         if (wr_ctl)
            timer_control_r <= wdat;
         if (wr_cpa)
            compare_constant_a_r <= wdat;
         if (wr_cpb)
            compare_constant_b_r <= wdat;
         if (wr_flg)
            out_sel_r <= wdat[3:0];
      end
   end

   // flags: set wins over any clear except standby
   // a flag clears by software only when it was read while set and a
   // zero is then written to it; a set in the cycle of the clear wins
   // and leaves the read mark standing, so a later zero write clears it without a new read
   // bit 2 is match b, bit 1 match a, bit 0 wrap; only the two match
   // flags may be cleared by the transfer controller's service pulse
   wire [2:0]  set_ev  = {match_b, match_a, wrap};
   wire [2:0]  wr_bits = {wdat[`TF_MATCH_B], wdat[`TF_MATCH_A],
                          wdat[`TF_WRAP]};

   // one flag per event, same software clear rule for all three
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : flag_bit
         // service ack for compare flags only
         wire ack = (g == 2) ? i_transfer_ack_b :
                    (g == 1) ? i_transfer_ack_a : 1'b0;

         // zero write clears, one is ignored
         // clear only after read while set
         wire sw_clr = wr_flg & ~wr_bits[g] & flags_seen_r[g];
         always @(posedge i_clk_sys or negedge i_rst_n) begin
            if (!i_rst_n) begin
               flags_r[g]      <= 1'b0;
               flags_seen_r[g] <= 1'b0;
            end else if (i_standby) begin
               flags_r[g]      <= 1'b0;
               flags_seen_r[g] <= 1'b0;
            end else if (set_ev[g]) begin
               flags_r[g]      <= 1'b1;
            end else if (sw_clr | (ack & flags_r[g])) begin
               flags_r[g]      <= 1'b0;
               flags_seen_r[g] <= 1'b0;
            end else if (rd_flg & flags_r[g]) begin
               flags_seen_r[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // wave output
   // the level changes only on a compare event; match b wins when both
   // events fall in one cycle; standby returns the level to zero
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wave_r <= 1'b0;
      end else if (i_standby) begin
         wave_r <= 1'b0;
      end else if (match_b) begin
         // match B takes priority when both fire
         case (out_sel_r[3:2])
            `OS_LOW:    wave_r <= 1'b0;
            `OS_HIGH:   wave_r <= 1'b1;
            `OS_TOGGLE: wave_r <= ~wave_r;
            default:    wave_r <= wave_r;
         endcase
      end else if (match_a) begin
         case (out_sel_r[1:0])
            `OS_LOW:    wave_r <= 1'b0;
            `OS_HIGH:   wave_r <= 1'b1;
            `OS_TOGGLE: wave_r <= ~wave_r;
            default:    wave_r <= wave_r;
         endcase
      end
   end

   // registered pins and requests
   // every pin and request is one flop after the state it shows, so
   // requests follow their flags and enables one clock late
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_timer_wave_out  <= 1'b0;
         o_timer_wave_oe_n <= 1'b1;
         o_match_a_irq     <= 1'b0;
         o_match_b_irq     <= 1'b0;
         o_wrap_irq        <= 1'b0;
      end else begin
         // low until first event, released when selects all zero
         o_timer_wave_out  <= wave_r;
         o_timer_wave_oe_n <= (out_sel_r == 4'h0);

         o_match_b_irq <= flags_r[2] & timer_control_r[`TC_MATCH_B_IE];
         o_match_a_irq <= flags_r[1] & timer_control_r[`TC_MATCH_A_IE];
         o_wrap_irq    <= flags_r[0] & timer_control_r[`TC_WRAP_IE];
      end
   end

   // read mux
   // unmapped addresses read as zero; bit 4 of the flag register
   // is fixed high; read data are taken on the taking edge, so a count
   // read shows the value before that edge's own update
   reg  [7:0]  rd_byte;
   always @* begin
      rd_byte = 8'h00;
      if (hit(i_avs_address, `IDX_TIMER_CONTROL))
         rd_byte = timer_control_r;
      else if (hit(i_avs_address, `IDX_TIMER_FLAGS))
         rd_byte = {flags_r, 1'b1, out_sel_r};
      else if (hit(i_avs_address, `IDX_COMPARE_A))
         rd_byte = compare_constant_a_r;
      else if (hit(i_avs_address, `IDX_COMPARE_B))
         rd_byte = compare_constant_b_r;
      else if (hit(i_avs_address, `IDX_TIMER_COUNT))
         rd_byte = timer_count_r;
   end

   // bus answer: one wait cycle, then waitrequest low one cycle
   // waitrequest rests high; readdata and response are loaded on the
   // taking edge and stand through the answer cycle; an unmapped
   // address gets the slave error code and reads as zero
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pend_r            <= 1'b0;
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h0000_0000;
         o_avs_response    <= 2'h0;
      end else if (take) begin
         // taken: answer in the next cycle
         pend_r            <= 1'b1;
         o_avs_waitrequest <= 1'b0;
         o_avs_readdata    <= {24'h000000, rd_byte};
         o_avs_response    <= mapped ? 2'h0 : 2'h2;
      end else begin
         // idle or answer cycle: wait again
         pend_r            <= 1'b0;
         o_avs_waitrequest <= 1'b1;
      end
   end

endmodule

// [tb/pin_model.sv]
// far-side model of the timer pins and the transfer controller
`timescale 1ns/1ps
module pin_model (
   // clock
   input  wire i_clk_sys,
   // pins towards the timer
   output reg  o_cnt,
   output reg  o_clr,
   output reg  o_ack_a,
   output reg  o_ack_b
);
   // idle levels
   initial {o_cnt, o_clr, o_ack_a, o_ack_b} = 4'h0;
   // count pin pulses, each level held past the minimum width
   task pulse(input integer n);
      begin
         repeat (n) begin
            @(posedge i_clk_sys);
            o_cnt <= 1'b1;
            repeat (3) @(posedge i_clk_sys);
            o_cnt <= 1'b0;
            repeat (2) @(posedge i_clk_sys);
         end
         @(posedge i_clk_sys);
      end
   endtask
   // clear pin pulse
   task clear;
      begin
         @(posedge i_clk_sys);
         o_clr <= 1'b1;
         repeat (3) @(posedge i_clk_sys);
         o_clr <= 1'b0;
         repeat (3) @(posedge i_clk_sys);
      end
   endtask
   task ack(input b);
      begin
         @(posedge i_clk_sys);
         o_ack_a <= !b;
         o_ack_b <= b;
         @(posedge i_clk_sys);
         {o_ack_a, o_ack_b} <= 2'h0;
         repeat (3) @(posedge i_clk_sys);
      end
   endtask
endmodule

// [tb/cmp_timer_sva.sv]
// port-level assertions for the compare timer
`timescale 1ns/1ps
module cmp_timer_sva (
   // clock and reset
   input wire        i_clk_sys,
   input wire        i_rst_n,
   // bus and controls
   input wire [15:0] i_avs_address,
   input wire        i_avs_read,
   input wire        i_avs_write,
   input wire [31:0] o_avs_readdata,
   input wire        o_avs_waitrequest,
   input wire [1:0]  o_avs_response,
   input wire        i_standby,
   input wire        i_transfer_ack_a,
   input wire        i_transfer_ack_b,
   // pins and requests
   input wire        o_timer_wave_oe_n,
   input wire        o_match_a_irq,
   input wire        o_match_b_irq,
   input wire        o_wrap_irq
);
   // anything that may lower a request
   wire any_clr = i_avs_write | i_transfer_ack_a | i_transfer_ack_b | i_standby;
   wire req = i_avs_read | i_avs_write;
   wire mapped = i_avs_address >= 16'hfb40 && i_avs_address <= 16'hfb50
                 && i_avs_address[1:0] == 2'h0;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   answer_time_a: assert property (
      req && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("request not answered after one cycle");
   wait_stand_a: assert property (
      $fell(o_avs_waitrequest) |=> o_avs_waitrequest)
      else $error("answer held longer than one cycle");
   unmapped_rd_a: assert property (
      i_avs_read && o_avs_waitrequest && !mapped
      |=> o_avs_response == 2'h2 && o_avs_readdata == 32'h0)
      else $error("unmapped read not refused");
   mapped_ok_a: assert property (
      req && o_avs_waitrequest && mapped
      |=> o_avs_response == 2'h0 && o_avs_readdata[31:8] == 24'h0)
      else $error("mapped access answered badly");
   ack_a_clear_a: assert property (
      i_transfer_ack_a |-> ##[1:3] !o_match_a_irq)
      else $error("service of match a left request up");
   ack_b_clear_a: assert property (
      i_transfer_ack_b |-> ##[1:3] !o_match_b_irq)
      else $error("service of match b left request up");
   irq_a_hold_a: assert property (
      $fell(o_match_a_irq) |-> $past(any_clr) || $past(any_clr, 2))
      else $error("match a request dropped on its own");
   irq_b_hold_a: assert property (
      $fell(o_match_b_irq) |-> $past(any_clr) || $past(any_clr, 2))
      else $error("match b request dropped on its own");
   wrap_hold_a: assert property (
      $fell(o_wrap_irq) |-> $past(any_clr) || $past(any_clr, 2))
      else $error("wrap request dropped on its own");
   oe_cause_a: assert property (
      $fell(o_timer_wave_oe_n) |-> $past(i_avs_write) || $past(i_avs_write, 2))
      else $error("wave output enabled without a write");
endmodule
bind cmp_timer cmp_timer_sva i_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
   .i_standby(i_standby), .i_transfer_ack_a(i_transfer_ack_a),
   .i_transfer_ack_b(i_transfer_ack_b), .o_timer_wave_oe_n(o_timer_wave_oe_n),
   .o_match_a_irq(o_match_a_irq), .o_match_b_irq(o_match_b_irq),
   .o_wrap_irq(o_wrap_irq));

// [tb/cmp_timer_tb.sv]
// self-checking bench for the compare timer
`timescale 1ns/1ps
module cmp_timer_tb;
   localparam [15:0] A_CTL = 16'hfb40, A_FLG = 16'hfb44, A_CA = 16'hfb48;
   localparam [15:0] A_CB = 16'hfb4c, A_CNT = 16'hfb50;
   reg  [15:0] addr;
   reg         clk, rst_n, rd, wr, standby;
   reg  [31:0] wdata, seed, q;
   reg  [1:0]  r;
   reg  [2:0]  c;
   reg  [3:0]  be;
   wire [31:0] rdata;
   wire [1:0]  resp;
   wire        wait_req, cnt_pin, clr_pin, ack_a, ack_b;
   wire        wave, oe_n, irq_a, irq_b, irq_w;
   integer     fails, compares, i, n, d;
   // device and far side
   cmp_timer i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(be), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wait_req), .o_avs_response(resp),
      .i_standby(standby), .i_transfer_ack_a(ack_a), .i_transfer_ack_b(ack_b),
      .i_external_count_in(cnt_pin), .i_external_clear_in(clr_pin),
      .o_timer_wave_out(wave), .o_timer_wave_oe_n(oe_n),
      .o_match_a_irq(irq_a), .o_match_b_irq(irq_b), .o_wrap_irq(irq_w));
   pin_model i_pins (.i_clk_sys(clk), .o_cnt(cnt_pin), .o_clr(clr_pin),
      .o_ack_a(ack_a), .o_ack_b(ack_b));
   // clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // model of external counting per clock code
   function integer ext_exp(input [2:0] k, input integer p);
      ext_exp = (k == 3'h5 || k == 3'h6) ? p : (k == 3'h7) ? 2 * p : 0;
   endfunction
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("Error %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // one bus cycle, held until waitrequest is sampled low
   task bus(input w, input [15:0] a, input [7:0] dt);
      integer k;
      begin
         @(posedge clk);
         addr <= a;
         rd <= !w;
         wr <= w;
         wdata <= {seed[31:8], dt};
         k = 0;
         @(posedge clk);
         while (wait_req !== 1'b0 && k < 20) begin
            @(posedge clk);
            k = k + 1;
         end
         if (k == 20) begin
            fails = fails + 1;
            report_and_stop;
         end
         q = rdata;
         r = resp;
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask
   task wr8(input [15:0] a, input [7:0] dt);
      bus(1'b1, a, dt);
   endtask
   task rdc(input [15:0] a, input [7:0] e);
      begin
         bus(1'b0, a, 8'h0);
         chk("readdata", q, {24'h0, e});
         chk("response", {30'h0, r}, 32'h0);
      end
   endtask
   task rst_chk;
      begin
         rdc(A_CTL, 8'h00);
         rdc(A_FLG, 8'h10);
         rdc(A_CA, 8'hff);
         rdc(A_CB, 8'hff);
         rdc(A_CNT, 8'h00);
      end
   endtask
   // oe_n, wave, match a, match b, wrap
   task pinc(input [4:0] e);
      begin
         @(negedge clk);
         chk("pins", {27'h0, oe_n, wave, irq_a, irq_b, irq_w}, {27'h0, e});
      end
   endtask
   task report_and_stop;
      begin
         $display("compares %0d fails %0d", compares, fails);
         if (fails == 0 && compares > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // watchdog
   initial begin
      repeat (40000) @(posedge clk);
      fails = fails + 1;
      report_and_stop;
   end
   // main sequence
   initial begin
      {rd, wr, standby, rst_n} = 4'h0;
      addr = 16'h0;
      wdata = 32'h0;
      be = 4'h1;
      fails = 0;
      compares = 0;
      seed = 32'hd75b8b0a;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rst_chk;
      bus(1'b0, 16'h0000, 8'h0);
      chk("unmapped", {q[29:0], r}, 32'h2);
      for (i = 0; i < 4; i = i + 1) begin
         seed = lfsr(seed);
         wr8((i < 3) ? A_CA + 16'(4 * i) : A_CTL, seed[7:0]);
         bus(1'b0, (i < 3) ? A_CA + 16'(4 * i) : A_CTL, 8'h0);
         chk("rw_byte", q, {24'h0, seed[7:0]});
      end
      wr8(A_CA, 8'ha5);
      be <= 4'h0;
      wr8(A_CA, 8'h5a);
      be <= 4'h1;
      rdc(A_CA, 8'ha5);
      for (n = 0; n < 5; n = n + 1) begin
         c = (n < 2) ? 3'(4 * n) : 3'(n + 3);
         wr8(A_CTL, 8'h00);
         wr8(A_CNT, 8'h00);
         wr8(A_CTL, {5'h0, c});
         i_pins.pulse(3);
         wr8(A_CTL, 8'h00);
         rdc(A_CNT, 8'(ext_exp(c, 3)));
      end
      for (n = 1; n < 4; n = n + 1) begin
         d = (n == 3) ? 1024 : (n == 2) ? 64 : 8;
         wr8(A_CNT, 8'h00);
         wr8(A_CTL, 8'(n));
         repeat (4 * d) @(posedge clk);
         wr8(A_CTL, 8'h00);
         bus(1'b0, A_CNT, 8'h0);
         chk("prescale", {31'h0, q == 32'h4 || q == 32'h5}, 32'h1);
      end
      bus(1'b0, A_FLG, 8'h0);
      wr8(A_FLG, 8'h03);
      pinc(5'b00000);
      wr8(A_CB, 8'hff);
      wr8(A_CA, 8'h03);
      wr8(A_CNT, 8'h00);
      wr8(A_CTL, 8'h4d);
      i_pins.pulse(3);
      rdc(A_CNT, 8'h03);
      rdc(A_FLG, 8'h13);
      i_pins.pulse(1);
      rdc(A_CNT, 8'h00);
      rdc(A_FLG, 8'h53);
      pinc(5'b01100);
      i_pins.ack(1'b0);
      rdc(A_FLG, 8'h13);
      wr8(A_CB, 8'h02);
      wr8(A_FLG, 8'h07);
      wr8(A_CTL, 8'h95);
      i_pins.pulse(3);
      rdc(A_CNT, 8'h00);
      rdc(A_FLG, 8'h97);
      pinc(5'b00010);
      wr8(A_FLG, 8'hf7);
      rdc(A_FLG, 8'h97);
      wr8(A_FLG, 8'h77);
      rdc(A_FLG, 8'h17);
      pinc(5'b00000);
      i_pins.ack(1'b1);
      wr8(A_CTL, 8'h25);
      wr8(A_CNT, 8'hff);
      i_pins.pulse(1);
      rdc(A_CNT, 8'h00);
      rdc(A_FLG, 8'h37);
      pinc(5'b00001);
      wr8(A_CTL, 8'h05);
      pinc(5'b00000);
      wr8(A_CTL, 8'h1d);
      wr8(A_CNT, 8'h00);
      i_pins.pulse(2);
      rdc(A_CNT, 8'h02);
      i_pins.clear;
      rdc(A_CNT, 8'h00);
      @(posedge clk);
      standby <= 1'b1;
      repeat (2) @(posedge clk);
      standby <= 1'b0;
      rst_chk;
      pinc(5'b10000);
      report_and_stop;
   end
endmodule
